// ===== hw/cisel_defs.svh
/*
 Register offsets, field positions and reset values for the counter
 input-select and interrupt-acknowledge block.
 Assumes inclusion by bare name from hw/ sources.
*/
`ifndef CISEL_DEFS_SVH
`define CISEL_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CISEL_OFF_INPUT_CONFIG 8'h00
`define CISEL_OFF_EVEN_ACK 8'h04
`define CISEL_OFF_ODD_ACK 8'h08
`define CISEL_OFF_STATUS 8'h0C
`define CISEL_OFF_IRQ_STATUS 8'h10
`define CISEL_OFF_IRQ_MASK 8'h14
`define CISEL_OFF_GATING 8'h18

// ****************************************
// Input configuration fields
// ****************************************
`define CISEL_BIT_SRC_INVERT 15
`define CISEL_BIT_OUT_INVERT 14
`define CISEL_BIT_GATE_MERGE 13
`define CISEL_BIT_GATE_LOAD 12
`define CISEL_GATE_SEL_HI 11
`define CISEL_GATE_SEL_LO 7
`define CISEL_SRC_SEL_HI 6
`define CISEL_SRC_SEL_LO 2

// ****************************************
// Acknowledge fields
// ****************************************
`define CISEL_BIT_TC_IRQ_CLR 14
`define CISEL_BIT_ERR_CLR_EVEN 6
`define CISEL_BIT_ERR_CLR_ODD 2

// ****************************************
// Reset values and bus answers
// ****************************************
`define CISEL_RST_CONFIG 16'h0000
`define CISEL_RST_MASK 2'h0
`define CISEL_RESP_OKAY 2'h0
`define CISEL_RESP_SLVERR 2'h2

`endif

// ===== hw/cisel_pkg.sv
/*
 Types shared by the counter input-select block.
 Assumes cisel_defs.svh holds the numeric constants.
*/
package cisel_pkg;

   // Bus slave write phase
   typedef enum logic [1:0]
   {
      CISEL_WR_IDLE = 2'b00,
      CISEL_WR_RESP = 2'b01
   } cisel_wr_t;

   // Which acknowledge word this counter decodes
   typedef enum logic
   {
      CISEL_POS_EVEN = 1'b0,
      CISEL_POS_ODD = 1'b1
   } cisel_pos_t;

   // Whole module state except the pin synchronisers
   typedef struct packed
   {
      logic [15:0] config_word;
      logic gating_level;
      logic src_clean;
      logic term_count_flag;
      logic term_count_err_flag;
      logic [1:0] irq_status;
      logic [1:0] irq_mask;
      logic tc_clear_pulse;
      logic err_clear_pulse;
      logic aw_held;
      logic [7:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      cisel_wr_t wr_state;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cisel_state_t;

endpackage

// ===== hw/cisel_top.sv
/*
 Input routing, polarity control, gate merging, gate-driven load choice and
 terminal-count acknowledge for one counter, with an AXI4-Lite register slave.
 Assumes pins and trigger lines are asynchronous; adjacent-counter and core
 signals come from logic on clk_sys. The counting core sits outside.
*/
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cisel_defs.svh"

module cisel_top
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Which acknowledge word this counter answers to
   input wire cisel_pkg::cisel_pos_t counter_pos,
   // Dedicated, shared and trigger pins (asynchronous)
   input wire logic own_src_pin,
   input wire logic own_gate_pin,
   input wire logic [7:0] shared_src_pin,
   input wire logic [7:0] shared_gate_pin,
   input wire logic [6:0] trigger_bus_line,
   // Timebases and adjacent counter (clk_sys domain)
   input wire logic timebase_20m,
   input wire logic timebase_100k,
   input wire logic timebase_max,
   input wire logic adj_src,
   input wire logic adj_gate,
   input wire logic adj_out,
   input wire logic adj_terminal_count,
   // Counting core
   input wire logic counting,
   input wire logic core_out,
   input wire logic terminal_count,
   input wire logic terminal_count_err,
   // Routed signals to the core and pins
   output logic count_src,
   output logic gate_eff,
   output logic sel_gate,
   output logic sel_load_a,
   output logic gate_chooses_load,
   output logic gating_style,
   output logic counter_out,
   output logic term_count_flag,
   output logic term_count_err_flag,
   output logic irq,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import cisel_pkg::*;

   // ****************************************
   // Select decoding
   // ****************************************

   // Gate mux; unlisted codes give low so no stray edges reach the core
   function automatic logic gate_pick(input logic [4:0] code, input logic [7:0] sp,
      input logic [6:0] tb, input logic own_s, input logic own_g, input logic a_src,
      input logic a_out);
      logic r;
      r = 1'b0;
      if (code == 5'h00)
         r = own_s;
      else if (code == 5'h01)
         r = own_g;
      else if (code >= 5'h02 && code <= 5'h09)
         r = sp[3'(code - 5'h02)];
      else if (code == 5'h0A)
         r = a_src;
      else if (code >= 5'h0B && code <= 5'h11)
         r = tb[3'(code - 5'h0B)];
      else if (code == 5'h14)
         r = a_out;
      return r; // codes 18, 19 and 21 to 31 fall to low
   endfunction

   // Source mux; same low default for unassigned codes
   function automatic logic src_pick(input logic [4:0] code, input logic [7:0] sp,
      input logic [6:0] tb, input logic own_s, input logic t20, input logic t100,
      input logic tmax, input logic a_gate, input logic a_tc);
      logic r;
      r = 1'b0;
      if (code == 5'h00)
         r = t20;
      else if (code == 5'h01)
         r = own_s;
      else if (code >= 5'h02 && code <= 5'h09)
         r = sp[3'(code - 5'h02)];
      else if (code == 5'h0A)
         r = a_gate;
      else if (code >= 5'h0B && code <= 5'h11)
         r = tb[3'(code - 5'h0B)];
      else if (code == 5'h12)
         r = t100;
      else if (code == 5'h13)
         r = a_tc;
      else if (code == 5'h1E)
         r = tmax;
      return r; // codes 20 to 29 and 31 low
   endfunction

   // Word decode shared by the write and read paths; low address bits ignored
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction

   // ****************************************
   // State
   // ****************************************
   cisel_state_t st;
   cisel_state_t next_st;
   logic [31:0] in_word;
   logic [15:0] pins_async;
   logic [24:0] pin_s1;
   logic [24:0] pin_s2;
   logic [7:0] gsel_pin;
   logic [7:0] ssel_pin;
   logic [6:0] trig_s;
   logic own_src_s;
   logic own_gate_s;
   logic raw_gate;
   logic raw_src;
   logic merged_gate;

   // Two-flop synchronisers for every asynchronous pin
   assign pins_async = {shared_src_pin, shared_gate_pin};
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_s1 <= 25'h0;
         pin_s2 <= 25'h0;
      end
      else
      begin
         pin_s1 <= {trigger_bus_line, own_src_pin, own_gate_pin, pins_async};
         pin_s2 <= pin_s1;
      end
   end
   assign {trig_s, own_src_s, own_gate_s, ssel_pin, gsel_pin} = pin_s2;

   // ****************************************
   // Routing
   // ****************************************

   // Multiplexers read only the second synchroniser stage
   always_comb
   begin
      raw_gate = gate_pick(st.config_word[`CISEL_GATE_SEL_HI:`CISEL_GATE_SEL_LO],
         gsel_pin, trig_s, own_src_s, own_gate_s, adj_src, adj_out);
      raw_src = src_pick(st.config_word[`CISEL_SRC_SEL_HI:`CISEL_SRC_SEL_LO],
         ssel_pin, trig_s, own_src_s, timebase_20m, timebase_100k, timebase_max,
         adj_gate, adj_terminal_count);
      // Idle counter with merge sees only the adjacent output
      if (st.config_word[`CISEL_BIT_GATE_MERGE] && !counting)
         merged_gate = adj_out;
      else if (st.config_word[`CISEL_BIT_GATE_MERGE])
         merged_gate = raw_gate | adj_out;
      else
         merged_gate = raw_gate;
   end

   // count_src registered, gate, load and out combinational; source inversion lands before the core's edge detect
   assign count_src = st.src_clean;
   assign gate_eff = merged_gate;
   assign sel_gate = raw_gate;
   assign gate_chooses_load = st.config_word[`CISEL_BIT_GATE_LOAD];
   assign sel_load_a = gate_chooses_load ? merged_gate : 1'b1;
   assign gating_style = st.gating_level;
   assign counter_out = core_out ^ st.config_word[`CISEL_BIT_OUT_INVERT];
   assign term_count_flag = st.term_count_flag;
   assign term_count_err_flag = st.term_count_err_flag;
   assign irq = |(st.irq_status & st.irq_mask);

   // ****************************************
   // Bus slave handshakes
   // ****************************************
   assign s_axi_awready = !st.aw_held && st.wr_state == CISEL_WR_IDLE;
   assign s_axi_wready = !st.w_held && st.wr_state == CISEL_WR_IDLE;
   assign s_axi_bvalid = st.wr_state == CISEL_WR_RESP;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = !st.rvalid;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb
   begin
      logic do_write;
      logic [15:0] lo;
      next_st = st;
      do_write = 1'b0;
      lo = 16'h0000;
      in_word = 32'h00000000;
      next_st.tc_clear_pulse = 1'b0;
      next_st.err_clear_pulse = 1'b0;
      next_st.src_clean = raw_src ^ st.config_word[`CISEL_BIT_SRC_INVERT];
      // Capture address and data in either order
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_st.aw_held = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_st.w_held = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_strb = s_axi_wstrb;
      end
      if (st.aw_held && st.w_held && st.wr_state == CISEL_WR_IDLE)
      begin
         do_write = 1'b1;
         next_st.aw_held = 1'b0;
         next_st.w_held = 1'b0;
         next_st.wr_state = CISEL_WR_RESP;
         next_st.bresp = `CISEL_RESP_OKAY;
      end
      if (st.wr_state == CISEL_WR_RESP && s_axi_bready)
         next_st.wr_state = CISEL_WR_IDLE;
      // Apply strobed low half-word
      lo = st.w_data[15:0];
      if (do_write)
      begin
         if (reg_hit(st.aw_addr, `CISEL_OFF_INPUT_CONFIG))
         begin
            if (st.w_strb[0])
               next_st.config_word[7:0] = lo[7:0];
            if (st.w_strb[1])
               next_st.config_word[15:8] = lo[15:8];
         end
         else if (reg_hit(st.aw_addr, `CISEL_OFF_EVEN_ACK))
         begin
            if (counter_pos == CISEL_POS_EVEN)
            begin
               next_st.tc_clear_pulse = st.w_strb[1] & lo[`CISEL_BIT_TC_IRQ_CLR];
               next_st.err_clear_pulse = st.w_strb[0] & lo[`CISEL_BIT_ERR_CLR_EVEN];
            end
         end
         else if (reg_hit(st.aw_addr, `CISEL_OFF_ODD_ACK))
         begin
            if (counter_pos == CISEL_POS_ODD)
            begin
               next_st.tc_clear_pulse = st.w_strb[1] & lo[`CISEL_BIT_TC_IRQ_CLR];
               next_st.err_clear_pulse = st.w_strb[0] & lo[`CISEL_BIT_ERR_CLR_ODD];
            end
         end
         else if (reg_hit(st.aw_addr, `CISEL_OFF_IRQ_STATUS))
         begin
            if (st.w_strb[0])
               next_st.irq_status = st.irq_status & ~lo[1:0];
         end
         else if (reg_hit(st.aw_addr, `CISEL_OFF_IRQ_MASK))
         begin
            if (st.w_strb[0])
               next_st.irq_mask = lo[1:0];
         end
         else if (reg_hit(st.aw_addr, `CISEL_OFF_GATING))
         begin
            if (st.w_strb[0])
               next_st.gating_level = lo[0];
         end
         else
            next_st.bresp = `CISEL_RESP_SLVERR;
      end
      // Flags: clear pulse from last cycle, but a new event wins
      if (st.tc_clear_pulse)
      begin
         next_st.term_count_flag = 1'b0;
         next_st.irq_status[0] = 1'b0;
      end
      if (st.err_clear_pulse)
         next_st.term_count_err_flag = 1'b0;
      if (terminal_count)
      begin
         next_st.term_count_flag = 1'b1;
         next_st.irq_status[0] = 1'b1;
      end
      if (terminal_count_err)
      begin
         next_st.term_count_err_flag = 1'b1;
         next_st.irq_status[1] = 1'b1;
      end
      // Reads: config and ack words are write-only and read zero
      if (s_axi_arvalid && s_axi_arready)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp = `CISEL_RESP_OKAY;
         if (reg_hit(s_axi_araddr, `CISEL_OFF_INPUT_CONFIG))
            in_word = 32'h00000000;
         else if (reg_hit(s_axi_araddr, `CISEL_OFF_EVEN_ACK))
            in_word = 32'h00000000;
         else if (reg_hit(s_axi_araddr, `CISEL_OFF_ODD_ACK))
            in_word = 32'h00000000;
         else if (reg_hit(s_axi_araddr, `CISEL_OFF_STATUS))
            in_word = {28'h0000000, counting, sel_gate, st.term_count_err_flag,
               st.term_count_flag};
         else if (reg_hit(s_axi_araddr, `CISEL_OFF_IRQ_STATUS))
            in_word = {30'h0, st.irq_status};
         else if (reg_hit(s_axi_araddr, `CISEL_OFF_IRQ_MASK))
            in_word = {30'h0, st.irq_mask};
         else if (reg_hit(s_axi_araddr, `CISEL_OFF_GATING))
            in_word = {31'h0, st.gating_level};
         else
            next_st.rresp = `CISEL_RESP_SLVERR;
         next_st.rdata = in_word;
      end
      else if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st <= '0;
         st.config_word <= `CISEL_RST_CONFIG;
         st.irq_mask <= `CISEL_RST_MASK;
         st.wr_state <= CISEL_WR_IDLE;
      end
      else
         st <= next_st;
   end

endmodule
`default_nettype wire

// ===== verif/cisel_lines.sv
/*
 Far-side model: drives the asynchronous pin and trigger lines.
 Assumes the bench supplies the wanted levels.
*/
`timescale 1ns/1ps
`default_nettype none
module cisel_lines
(
   // Wanted levels
   input wire logic [24:0] lvl,
   // Pin and trigger lines
   output wire logic own_src_pin,
   output wire logic own_gate_pin,
   output wire logic [7:0] shared_src_pin,
   output wire logic [7:0] shared_gate_pin,
   output wire logic [6:0] trigger_bus_line
);
   // Lines move 3 ns off the clock edge, as real async pins would
   assign #3 {trigger_bus_line, shared_gate_pin, shared_src_pin,
      own_gate_pin, own_src_pin} = lvl;
endmodule
`default_nettype wire

// ===== verif/cisel_props.sv
/*
 Concurrent checks on the input-select block ports.
 Assumes binding into cisel_top; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cisel_chk
(
   // Clock, reset, routing
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic counting,
   input wire logic adj_out,
   input wire logic sel_gate,
   input wire logic gate_eff,
   input wire logic sel_load_a,
   input wire logic gate_chooses_load,
   // Events and flags
   input wire logic terminal_count,
   input wire logic terminal_count_err,
   input wire logic term_count_flag,
   input wire logic term_count_err_flag,
   // Write response
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   logic [3:0] since_resp;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // Cycles since a write answer; saturates so an old write never excuses a clear
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         since_resp <= 4'hF;
      else if (s_axi_bvalid && s_axi_bready)
         since_resp <= 4'h0;
      else if (since_resp != 4'hF)
         since_resp <= since_resp + 4'h1;
   end
   // ****************
   // Assertions
   // ****************
   sequence s_tc_event;
      terminal_count ##1 term_count_flag;
   endsequence
   sequence s_err_event;
      terminal_count_err ##1 term_count_err_flag;
   endsequence
   a_gate_cause: assert property (gate_eff |-> sel_gate || adj_out)
      else $error("gate with no cause");
   a_gate_counting: assert property (counting && sel_gate |-> gate_eff)
      else $error("selected gate lost");
   a_load_follows: assert property (gate_chooses_load |-> sel_load_a == gate_eff)
      else $error("load choice not gate");
   a_load_fixed: assert property (!gate_chooses_load |-> sel_load_a)
      else $error("load B without gate choice");
   a_tc_set: assert property (terminal_count |-> s_tc_event)
      else $error("count flag not set");
   a_err_set: assert property (terminal_count_err |-> s_err_event)
      else $error("error flag not set");
   a_tc_clear: assert property ($fell(term_count_flag) |-> since_resp <= 4'h3)
      else $error("count flag cleared unasked");
   a_err_clear: assert property ($fell(term_count_err_flag) |-> since_resp <= 4'h3)
      else $error("error flag cleared unasked");
endmodule
bind cisel_top cisel_chk u_chk
(
   .clk_sys, .arst_n, .counting, .adj_out, .sel_gate, .gate_eff, .sel_load_a,
   .gate_chooses_load, .terminal_count, .terminal_count_err, .term_count_flag,
   .term_count_err_flag, .s_axi_bvalid, .s_axi_bready
);
`default_nettype wire

// ===== verif/test_counter_input_select_and_irq_ack.sv
/*
 Self-checking bench for the input-select block.
 Assumes cisel_top, cisel_lines and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cisel_defs.svh"
module test_counter_input_select_and_irq_ack;
   import cisel_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   cisel_pos_t counter_pos = CISEL_POS_EVEN;
   logic [31:0] stim = 32'h0;
   logic counting = 1'b0, core_out = 1'b0, terminal_count = 1'b0, terminal_count_err = 1'b0;
   logic count_src, gate_eff, sel_gate, sel_load_a, gate_chooses_load, gating_style;
   logic counter_out, term_count_flag, term_count_err_flag, irq;
   wire logic own_src_pin, own_gate_pin;
   wire logic [7:0] shared_src_pin, shared_gate_pin;
   wire logic [6:0] trigger_bus_line;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int err_count = 0, n_compared = 0, seed = 35;
   always #4 clk_sys = ~clk_sys;
   cisel_lines u_lines (.lvl(stim[24:0]), .own_src_pin, .own_gate_pin, .shared_src_pin,
      .shared_gate_pin, .trigger_bus_line);
   cisel_top u_dut (.*, .timebase_20m(stim[25]), .timebase_100k(stim[26]),
      .timebase_max(stim[27]), .adj_src(stim[28]), .adj_gate(stim[29]),
      .adj_out(stim[30]), .adj_terminal_count(stim[31]));
   // ****************
   // Expectations and bus tasks
   // ****************
   function automatic logic exp_src(input logic [4:0] k, input logic [31:0] s);
      case (k)
         5'h00: return s[25];
         5'h01: return s[0];
         5'h0A: return s[29];
         5'h12: return s[26];
         5'h13: return s[31];
         5'h1E: return s[27];
         default: return (k >= 2 && k <= 9) ? s[k] : (k >= 11 && k <= 17) ? s[k + 7] : 1'b0;
      endcase
   endfunction
   function automatic logic exp_gate(input logic [4:0] k, input logic [31:0] s);
      case (k)
         5'h00: return s[0];
         5'h01: return s[1];
         5'h0A: return s[28];
         5'h14: return s[30];
         default: return (k >= 2 && k <= 9) ? s[k + 8] : (k >= 11 && k <= 17) ? s[k + 7] : 1'b0;
      endcase
   endfunction
   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // A bounded wait that runs out ends the run as a failure
   task automatic fail_if(input int n);
      if (n >= 40)
      begin
         err_count++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid && n < 40);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
      fail_if(n);
      // Let write side effects land
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid && n < 40);
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      chk(s_axi_rresp, er);
      fail_if(n);
   endtask
   task automatic pulse(input logic [1:0] v);
      @(posedge clk_sys);
      {terminal_count_err, terminal_count} <= v;
      @(posedge clk_sys);
      {terminal_count_err, terminal_count} <= 2'b00;
      @(posedge clk_sys);
   endtask
   // Main sequence: reset, mux sweep, acknowledges, interrupt
   initial
   begin
      logic [31:0] d, eb;
      logic [15:0] cfg;
      logic [4:0] ex;
      logic [7:0] ack;
      logic g, ge;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      chk(sel_load_a, 1'b1);
      rd(`CISEL_OFF_INPUT_CONFIG, d, `CISEL_RESP_OKAY);
      chk(d, 32'h0);
      rd(8'h1C, d, `CISEL_RESP_SLVERR);
      chk(d, 32'h0);
      wr(8'h1C, 32'hFFFF, `CISEL_RESP_SLVERR);
      // Level gating set first, though gate-driven load choice does not read it
      wr(`CISEL_OFF_GATING, 32'h1, `CISEL_RESP_OKAY);
      chk(gating_style, 1'b1);
      for (int i = 0; i < 64; i++)
      begin
         cfg = 16'($random(seed));
         cfg[6:2] = 5'(i);
         cfg[11:7] = 5'(31 - i);
         cfg[1:0] = 2'b00;
         wr(`CISEL_OFF_INPUT_CONFIG, {16'h0000, cfg}, `CISEL_RESP_OKAY);
         stim <= $random(seed);
         counting <= 1'($random(seed));
         core_out <= 1'($random(seed));
         repeat (5) @(posedge clk_sys);
         chk(count_src, exp_src(cfg[6:2], stim) ^ cfg[15]);
         g = exp_gate(cfg[11:7], stim);
         ge = cfg[13] ? (counting ? g | stim[30] : stim[30]) : g;
         ex = {g, ge, cfg[12] ? ge : 1'b1, cfg[12], core_out ^ cfg[14]};
         chk({sel_gate, gate_eff, sel_load_a, gate_chooses_load, counter_out}, ex);
      end
      for (int p = 0; p < 2; p++)
      begin
         counter_pos <= p ? CISEL_POS_ODD : CISEL_POS_EVEN;
         ack = p ? `CISEL_OFF_ODD_ACK : `CISEL_OFF_EVEN_ACK;
         eb = p ? 32'h4 : 32'h40;
         pulse(2'b11);
         chk({term_count_flag, term_count_err_flag}, 2'b11);
         wr(ack ^ 8'h0C, 32'h4044, `CISEL_RESP_OKAY);
         chk({term_count_flag, term_count_err_flag}, 2'b11);
         wr(ack, 32'h4000, `CISEL_RESP_OKAY);
         chk({term_count_flag, term_count_err_flag}, 2'b01);
         wr(ack, eb, `CISEL_RESP_OKAY);
         chk({term_count_flag, term_count_err_flag}, 2'b00);
         pulse(2'b11);
         chk({term_count_flag, term_count_err_flag}, 2'b11);
         wr(ack, 32'h4000 | eb, `CISEL_RESP_OKAY);
         chk({term_count_flag, term_count_err_flag}, 2'b00);
      end
      chk(irq, 1'b0);
      wr(`CISEL_OFF_IRQ_STATUS, 32'h3, `CISEL_RESP_OKAY);
      wr(`CISEL_OFF_IRQ_MASK, 32'h1, `CISEL_RESP_OKAY);
      pulse(2'b01);
      chk(irq, 1'b1);
      // Status word: core state, routed gate, error flag, count flag
      rd(`CISEL_OFF_STATUS, d, `CISEL_RESP_OKAY);
      chk(d, {28'h0, counting, g, 2'b01});
      rd(`CISEL_OFF_IRQ_STATUS, d, `CISEL_RESP_OKAY);
      chk(d[1:0], 2'b01);
      wr(ack, 32'h4000, `CISEL_RESP_OKAY);
      chk(irq, 1'b0);
      pulse(2'b10);
      chk(irq, 1'b0);
      wr(`CISEL_OFF_IRQ_MASK, 32'h2, `CISEL_RESP_OKAY);
      chk(irq, 1'b1);
      wr(`CISEL_OFF_IRQ_STATUS, 32'h2, `CISEL_RESP_OKAY);
      chk(irq, 1'b0);
      rd(`CISEL_OFF_IRQ_MASK, d, `CISEL_RESP_OKAY);
      chk(d, 32'h2);
      // Reset again mid-run: every setting must fall back
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      chk({gating_style, term_count_err_flag, irq, gate_chooses_load, sel_load_a}, 5'h01);
      repeat (2) @(posedge clk_sys);
      chk(count_src, stim[25]);
      rd(`CISEL_OFF_IRQ_MASK, d, `CISEL_RESP_OKAY);
      chk(d, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
